// ---- src/hpp_defines.svh ----
`ifndef HPP_DEFINES_SVH
`define HPP_DEFINES_SVH

// register indices on the three address lines
`define HPP_ADDR_CAUSE   3'h0
`define HPP_ADDR_INDEX   3'h1
`define HPP_ADDR_DATA    3'h2
`define HPP_ADDR_STATUS  3'h3

// field positions
`define HPP_CAUSE_HOOK   0
`define HPP_CAUSE_HOST   1
`define HPP_STAT_HOOK    0
`define HPP_STAT_IDLE    1

// reset values
`define HPP_CAUSE_RST    8'h00
`define HPP_DATA_RST     8'h00

// timing
`define HPP_CLK_HZ       200000000
`define HPP_FRAME_NS     125000
`define HPP_FRAME_CYC    (`HPP_FRAME_NS / 5)
`define HPP_MCLK_DIV     8

`endif

// ---- src/hpp_pkg.sv ----
package hpp_pkg;
    // power mode out of reset
    typedef enum logic [1:0] {
        HPP_PWR_IDLE   = 2'b00,
        HPP_PWR_DATA   = 2'b01,
        HPP_PWR_VOICE  = 2'b11,
        HPP_PWR_DOWN   = 2'b10
    } hpp_pwr_t;

    // host strobe bundle
    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic [2:0] addr;
        logic [7:0] data;
    } hpp_bus_t;

    // strobe events after the synchroniser
    typedef struct packed {
        logic       rd_fall;
        logic       wr_rise;
        logic       rd_act;
        logic       wr_act;
        logic [2:0] addr;
        logic [7:0] data;
    } hpp_evt_t;
endpackage

// ---- src/hpp_sync.sv ----
`include "hpp_defines.svh"
module hpp_sync
    import hpp_pkg::*;
(
    // clock and reset
    input  wire logic     sys_clk,
    input  wire logic     rst,
    // raw host pins
    input  hpp_pkg::hpp_bus_t bus_in,
    // synchronised events
    output hpp_pkg::hpp_evt_t evt
);
    // ------------------------------------------------------------
    // two stage synchroniser plus edge detect
    // ------------------------------------------------------------
    hpp_bus_t s1_reg, s1_next;
    hpp_bus_t s2_reg, s2_next;
    hpp_bus_t s3_reg, s3_next;

    always_comb begin
        s1_next = bus_in;
        s2_next = s1_reg;
        s3_next = s2_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            s2_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
            s3_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end

    // edges only from stages two and three, never stage one
    always_comb begin
        evt.rd_act  = ~s2_reg.cs_n & ~s2_reg.rd_n;
        evt.wr_act  = ~s2_reg.cs_n & ~s2_reg.wr_n;
        // a select that falls after the strobe also opens a read
        evt.rd_fall = evt.rd_act & (s3_reg.rd_n | s3_reg.cs_n); // [RULE_14]
        // write data taken from the last low-strobe sample
        evt.wr_rise = s2_reg.wr_n & ~s3_reg.wr_n & ~s3_reg.cs_n; // [RULE_14]
        evt.addr    = evt.wr_rise ? s3_reg.addr : s2_reg.addr;
        evt.data    = s3_reg.data;
    end
endmodule

// ---- src/hpp_port.sv ----
// Behaviour
// [RULE_01] three address lines pick the register
// [RULE_02] no access unless select is low
// [RULE_03] eight data bits, bit 0 least significant
// [RULE_04] input on select+write, output on select+read
// [RULE_05] data floats otherwise
// [RULE_06] active low interrupt, updated once per frame; the code also releases it at once on a cause read
// [RULE_07] interrupt holds until cause register read
// [RULE_08] every hook switch edge raises interrupt
// [RULE_09] reset abandons activity, restores initial state
// [RULE_10] leaves reset in idle power mode
// [RULE_11] host clock keeps running during reset
// [RULE_12] read data driven after read strobe falls
// [RULE_13] write captured on write strobe rise
// [RULE_14] strobes synchronised before any state change
`include "hpp_defines.svh"
module hpp_port
    import hpp_pkg::*;
#(
    parameter int FRAME_CYC = `HPP_FRAME_CYC,
    parameter int MCLK_DIV  = `HPP_MCLK_DIV
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // host strobes and address
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [2:0] reg_addr,
    // host data bus
    input  wire logic [7:0] host_data_in,
    output logic      [7:0] host_data_out,
    output logic            host_data_oe,
    // interrupt and line side
    input  wire logic       hook_switch_in,
    output logic            irq_n,
    output logic            mclk_out,
    output hpp_pkg::hpp_pwr_t pwr_mode
);
    import hpp_pkg::*;

    hpp_bus_t bus_in;
    hpp_evt_t evt;

    assign bus_in = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n,
                      addr: reg_addr, data: host_data_in};

    hpp_sync hpp_sync_i (
        .sys_clk (sys_clk),
        .rst     (rst),
        .bus_in  (bus_in),
        .evt     (evt)
    );

    function automatic logic hit(input logic [2:0] a,
                                 input logic [2:0] r);
        hit = (a == r); // [RULE_01]
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] cause_reg,   cause_next;
    logic [7:0] index_reg,   index_next;
    logic [7:0] data_reg,    data_next;
    logic [7:0] dout_reg,    dout_next;
    logic       oe_reg,      oe_next;
    logic       irq_n_reg,   irq_n_next;
    logic       hook_s_reg,  hook_s_next;
    logic       hook_d_reg,  hook_d_next;
    logic       hook_v_reg,  hook_v_next;
    logic [$clog2(FRAME_CYC)-1:0] frm_reg, frm_next;
    // start values stand in for a reset the divider never gets
    logic [$clog2(MCLK_DIV)-1:0]  div_reg = '0, div_next;
    logic       mclk_reg = 1'b0, mclk_next;
    hpp_pwr_t   pwr_reg,     pwr_next;

    logic frame_tick;
    logic [7:0] rd_mux;
    logic cause_rd;
    logic hook_edge;

    // ------------------------------------------------------------
    // frame counter
    // ------------------------------------------------------------
    always_comb begin
        frame_tick = (frm_reg == ($clog2(FRAME_CYC))'(FRAME_CYC - 1));
        frm_next   = frame_tick ? '0 : frm_reg + 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin // [RULE_09]
            frm_reg <= '0;
        end else begin
            frm_reg <= frm_next;
        end
    end

    // ------------------------------------------------------------
    // host clock divider
    // ------------------------------------------------------------
    // no reset here so the host clock never stops; the start
    // value comes from the declaration
    always_comb begin
        div_next  = (div_reg == ($clog2(MCLK_DIV))'(MCLK_DIV/2 - 1))
                    ? '0 : div_reg + 1'b1; // [RULE_11]
        mclk_next = (div_reg == ($clog2(MCLK_DIV))'(MCLK_DIV/2 - 1))
                    ? ~mclk_reg : mclk_reg;
    end

    always_ff @(posedge sys_clk) begin
        div_reg  <= div_next; // [RULE_11]
        mclk_reg <= mclk_next;
    end

    // ------------------------------------------------------------
    // hook switch
    // ------------------------------------------------------------
    // two flops, then edge detect on the settled pair
    always_comb begin
        hook_s_next = hook_switch_in;
        hook_d_next = hook_s_reg;
        hook_v_next = hook_d_reg;
        hook_edge   = hook_v_reg ^ hook_d_reg; // [RULE_08]
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin // [RULE_09]
            // idle level of the pulled-up switch, so no false edge
            hook_s_reg <= 1'b1;
            hook_d_reg <= 1'b1;
            hook_v_reg <= 1'b1;
        end else begin
            hook_s_reg <= hook_s_next;
            hook_d_reg <= hook_d_next;
            hook_v_reg <= hook_v_next;
        end
    end

    // ------------------------------------------------------------
    // host access
    // ------------------------------------------------------------
    always_comb begin
        unique case (evt.addr)
            `HPP_ADDR_CAUSE:  rd_mux = cause_reg;
            `HPP_ADDR_INDEX:  rd_mux = index_reg;
            `HPP_ADDR_DATA:   rd_mux = data_reg;
            `HPP_ADDR_STATUS: rd_mux = {6'h00, pwr_reg == HPP_PWR_IDLE,
                                        hook_d_reg};
            default:          rd_mux = 8'h00;
        endcase

        cause_rd  = evt.rd_fall & hit(evt.addr, `HPP_ADDR_CAUSE);
        dout_next = evt.rd_fall ? rd_mux : dout_reg; // [RULE_12]
        oe_next   = evt.rd_act; // [RULE_02] [RULE_04] [RULE_05]

        index_next = index_reg;
        data_next  = data_reg;
        if (evt.wr_rise) begin // [RULE_13]
            if (hit(evt.addr, `HPP_ADDR_INDEX))
                index_next = evt.data;
            if (hit(evt.addr, `HPP_ADDR_DATA))
                data_next = evt.data; // [RULE_03]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin // [RULE_09]
            index_reg <= `HPP_DATA_RST;
            data_reg  <= `HPP_DATA_RST;
            dout_reg  <= 8'h00;
            oe_reg    <= 1'b0;
        end else begin
            index_reg <= index_next;
            data_reg  <= data_next;
            dout_reg  <= dout_next;
            oe_reg    <= oe_next;
        end
    end

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    always_comb begin
        // read clears, but a new hook edge in the same cycle wins
        cause_next = cause_rd ? `HPP_CAUSE_RST : cause_reg; // [RULE_07]
        if (hook_edge)
            cause_next[`HPP_CAUSE_HOOK] = 1'b1; // [RULE_08]

        // pin updated at frame tick only; a cause read releases it
        irq_n_next = irq_n_reg;
        if (cause_rd)
            irq_n_next = 1'b1; // [RULE_07]
        else if (frame_tick)
            irq_n_next = ~(|cause_reg); // [RULE_06]
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin // [RULE_09]
            cause_reg <= `HPP_CAUSE_RST;
            irq_n_reg <= 1'b1;
        end else begin
            cause_reg <= cause_next;
            irq_n_reg <= irq_n_next;
        end
    end

    // ------------------------------------------------------------
    // power mode
    // ------------------------------------------------------------
    // no mode register here, so the block stays where reset left it
    always_comb begin
        pwr_next = pwr_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pwr_reg <= HPP_PWR_IDLE; // [RULE_10]
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    assign host_data_out = dout_reg;
    assign host_data_oe  = oe_reg;
    assign irq_n         = irq_n_reg;
    assign mclk_out      = mclk_reg;
    assign pwr_mode      = pwr_reg;
endmodule

// ---- bench/hpp_port_chk.sv ----
module hpp_port_chk
    import hpp_pkg::*;
#(
    parameter int FRAME_CYC = 50
) (
    // clock, reset and host side
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic [2:0] reg_addr,
    input wire logic       hook_switch_in,
    // device side
    input wire logic       host_data_oe,
    input wire logic       irq_n,
    input wire logic       mclk_out,
    input wire hpp_pwr_t   pwr_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOOK_MAX = FRAME_CYC + 8;
    logic rd_sel;
    logic cause_rd;
    assign rd_sel = !cs_n && !rd_n;
    assign cause_rd = rd_sel && reg_addr == 3'h0;
    // mirror of the frame counter, restarted by the same reset
    int frm_cnt;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            frm_cnt <= 0;
        end else begin
            frm_cnt <= (frm_cnt == FRAME_CYC - 1) ? 0 : frm_cnt + 1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_rd_held; rd_sel[*5]; endsequence
    sequence s_idle; (!rd_sel)[*5]; endsequence
    // two depths: synchroniser latency is 2 or 3 samples
    oe_cause_a: assert property (
        host_data_oe |-> $past(rd_sel, 2) || $past(rd_sel, 3))
        else $error("data driven without select and read");
    oe_read_a: assert property (s_rd_held |-> host_data_oe)
        else $error("read data not driven");
    float_a: assert property (s_idle |-> !host_data_oe)
        else $error("data bus not floated");
    irq_hold_a: assert property (
        (!irq_n && !cause_rd)[*6] |=> !irq_n)
        else $error("interrupt dropped without cause read");
    rst_quiet_a: assert property (disable iff (1'b0)
        rst |=> !host_data_oe && irq_n)
        else $error("outputs active in reset");
    idle_mode_a: assert property (
        $fell(rst) |-> (pwr_mode == HPP_PWR_IDLE)[*3])
        else $error("not idle after reset");
    mclk_run_a: assert property (disable iff (1'b0)
        rst |-> ##[1:8] $changed(mclk_out))
        else $error("host clock stopped in reset");
    hook_irq_a: assert property (
        $changed(hook_switch_in) |-> ##[1:HOOK_MAX] !irq_n)
        else $error("hook change raised no interrupt");
    irq_frame_a: assert property ($fell(irq_n) |-> frm_cnt == 0)
        else $error("interrupt asserted off the frame tick");
endmodule

bind hpp_port hpp_port_chk #(.FRAME_CYC(FRAME_CYC)) hpp_port_chk_i (
    .sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
    .reg_addr(reg_addr), .hook_switch_in(hook_switch_in),
    .host_data_oe(host_data_oe), .irq_n(irq_n), .mclk_out(mclk_out),
    .pwr_mode(pwr_mode));

// ---- bench/hpp_host_model.sv ----
module hpp_host_model (
    // clock and device data
    input  wire logic       sys_clk,
    input  wire logic [7:0] host_data_out,
    input  wire logic       host_data_oe,
    // host strobes and bus
    output logic            cs_n = 1'b1,
    output logic            rd_n = 1'b1,
    output logic            wr_n = 1'b1,
    output logic      [2:0] reg_addr = 3'h0,
    output logic      [7:0] host_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wd = 8'h00;
    logic       drv = 1'b0;
    // released bus shows the inverse, never a stale byte
    assign host_data = drv ? wd : host_data_oe ? host_data_out : ~wd;
    task automatic acc(input logic s, input logic w, input logic [2:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        reg_addr <= a;
        wd <= d;
        drv <= w;
        cs_n <= !s;
        rd_n <= w;
        wr_n <= !w;
        repeat (5) @(posedge sys_clk);
        q = host_data;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        drv <= 1'b0;
        cs_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
    endtask
endmodule

// ---- bench/tb_hpp_port.sv ----
module tb_hpp_port;
    import hpp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FC = 50;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic       hook_switch_in = 1'b1;
    logic       cs_n, rd_n, wr_n, host_data_oe, irq_n, mclk_out;
    logic [2:0] reg_addr;
    logic [7:0] host_data, host_data_out, q;
    hpp_pwr_t   pwr_mode;
    int         failures = 0;
    int         compares = 0;
    always #2.5 sys_clk = ~sys_clk;
    hpp_port #(.FRAME_CYC(FC), .MCLK_DIV(8)) hpp_port_i (
        .sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .reg_addr(reg_addr), .host_data_in(host_data),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .hook_switch_in(hook_switch_in), .irq_n(irq_n),
        .mclk_out(mclk_out), .pwr_mode(pwr_mode));
    hpp_host_model hpp_host_model_i (.sys_clk(sys_clk),
        .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .reg_addr(reg_addr),
        .host_data(host_data));
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic t_reset;
        chk("oe", 8'h00, {7'h0, host_data_oe});
        chk("irq", 8'h01, {7'h0, irq_n});
        hpp_host_model_i.acc(1, 0, 3'h3, 8'h00, q);
        chk("status", 8'h03, q);
    endtask
    task automatic t_rw;
        hpp_host_model_i.acc(1, 1, 3'h1, 8'hA5, q);
        hpp_host_model_i.acc(1, 1, 3'h2, 8'h3C, q);
        hpp_host_model_i.acc(1, 1, 3'h5, 8'hFF, q);
        hpp_host_model_i.acc(0, 1, 3'h1, 8'h66, q);
        hpp_host_model_i.acc(1, 0, 3'h1, 8'h00, q);
        chk("index", 8'hA5, q);
        hpp_host_model_i.acc(1, 0, 3'h2, 8'h00, q);
        chk("data", 8'h3C, q);
        hpp_host_model_i.acc(1, 0, 3'h5, 8'h00, q);
        chk("unmapped", 8'h00, q);
        hpp_host_model_i.acc(0, 0, 3'h2, 8'h00, q);
        chk("float", 8'hFF, q);
    endtask
    task automatic t_irq;
        int n;
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            hook_switch_in <= ~hook_switch_in;
            n = 0;
            while (irq_n !== 1'b0 && n < FC + 20) begin
                @(posedge sys_clk);
                n++;
            end
            chk("irq_set", 8'h00, {7'h0, irq_n});
            repeat (2 * FC) @(posedge sys_clk);
            chk("irq_held", 8'h00, {7'h0, irq_n});
            hpp_host_model_i.acc(1, 0, 3'h0, 8'h00, q);
            chk("cause", 8'h01, q);
            chk("irq_clr", 8'h01, {7'h0, irq_n});
        end
    endtask
    task automatic t_midrst;
        fork
            hpp_host_model_i.acc(1, 0, 3'h1, 8'h00, q);
            begin
                repeat (4) @(posedge sys_clk);
                rst <= 1'b1;
                repeat (3) @(posedge sys_clk);
                chk("rst_oe", 8'h00, {7'h0, host_data_oe});
                rst <= 1'b0;
            end
        join
        hpp_host_model_i.acc(1, 0, 3'h1, 8'h00, q);
        chk("rst_index", 8'h00, q);
        chk("rst_pwr", 8'h00, {6'h0, pwr_mode});
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_rw();
        t_irq();
        t_midrst();
        results();
    end
    // watchdog: a few hundred cycles of work at most
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        results();
    end
endmodule
